// File: design/gpio_expander_consts.vh
// Purpose : Shared constants of the serial port expander
// Assumes : 200 MHz reference clock
// Notes   : Definitions only
`ifndef GPIO_EXPANDER_CONSTS_VH
`define GPIO_EXPANDER_CONSTS_VH

// ==========================================================
// Clock and filter timing
// ==========================================================
`define CLK_MHZ        200
`define SPIKE_NS       50
`define SPIKE_CYC      ((`SPIKE_NS * `CLK_MHZ + 999) / 1000)
`define INIT_CYC       2'h3

// ==========================================================
// Register select codes (low bits of the command byte)
// ==========================================================
`define CMD_INPUT      2'h0
`define CMD_OUTPUT     2'h1
`define CMD_POLARITY   2'h2
`define CMD_DIRECTION  2'h3

// ==========================================================
// Reset values
// ==========================================================
`define RST_DIRECTION  8'hFF
`define RST_OUTPUT     8'hFF
`define RST_POLARITY   8'h00

// ==========================================================
// Bus framing
// ==========================================================
`define BITS_PER_BYTE  4'h8
`define LAST_TX_BIT    4'h7
`define BYTE_ADDR      2'h0
`define BYTE_CMD       2'h1
`define BYTE_DATA      2'h2

`endif

// File: design/pin_sync.v
// Purpose : Two-stage synchroniser for a group of pin levels
// Assumes : Inputs change outside the REF_CLK domain
// Notes   : First stage feeds only the second stage
`timescale 1ns/100ps

module pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk,      // Reference clock
    input  wire             rst_n,    // Async reset, active low
    input  wire [WIDTH-1:0] pin_in,   // Raw pin levels
    output reg  [WIDTH-1:0] pin_out   // Synchronised levels
);

    reg [WIDTH-1:0] meta_ff;

    // ==========================================================
    // Two flip-flop crossing
    // ==========================================================
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= {WIDTH{1'b0}};
            pin_out <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= pin_in;
            pin_out <= meta_ff;
        end
    end

endmodule // pin_sync

// File: design/line_filter.v
// Purpose : Synchronise and deglitch serial bus lines
// Assumes : Lines idle high
// Notes   : A level must hold FILT_CYC cycles before it passes
`timescale 1ns/100ps

module line_filter #(
    parameter WIDTH    = 2,
    parameter FILT_CYC = 10,
    parameter CW       = 4
) (
    input  wire             clk,      // Reference clock
    input  wire             rst_n,    // Async reset, active low
    input  wire [WIDTH-1:0] line_in,  // Raw bus lines
    output wire [WIDTH-1:0] line_out  // Filtered lines
);

    localparam integer  LAST_I = FILT_CYC - 1;
    localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

    genvar g;
    // ==========================================================
    // One filter per line
    // ==========================================================
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_line
            reg [1:0]    sync_ff;
            reg [CW-1:0] cnt_ff;
            reg          level_ff;
            // Sync, then accept only a level stable long enough
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_ff  <= 2'h3;
                    cnt_ff   <= {CW{1'b0}};
                    level_ff <= 1'b1;
                end else begin
                    sync_ff <= {sync_ff[0], line_in[g]};
                    if (sync_ff[1] == level_ff) begin
                        cnt_ff <= {CW{1'b0}};
                    end else if (cnt_ff == LAST) begin
                        cnt_ff   <= {CW{1'b0}};
                        level_ff <= sync_ff[1];
                    end else begin
                        cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
                    end
                end
            end
            assign line_out[g] = level_ff;
        end
    endgenerate

endmodule // line_filter

// File: design/gpio_expander.v
// Purpose : Eight-pin port expander behind a serial two-wire target
// Assumes : REF_CLK 200 MHz, far faster than the bus clock
// Notes   : Address straps are 2-bit codes, captured after reset
`timescale 1ns/100ps
`include "gpio_expander_consts.vh"

module gpio_expander #(
    parameter       WIDTH      = 8,
    parameter [0:0] ADDR_FIXED = 1'b1    // Arbitrary fixed address bit
) (
    input  wire             REF_CLK,     // 200 MHz clock
    input  wire             RSTN,        // Power-on reset, active low
    input  wire             SCL_IN,      // Bus clock level
    input  wire             SDA_IN,      // Bus data level
    output wire             SDA_OUT,     // Data drive value, always low
    output wire             SDA_OE,      // Data pulled low when high
    input  wire [1:0]       ADDR_SELECT_PIN_0, // Strap code, address bits 1:0
    input  wire [1:0]       ADDR_SELECT_PIN_1, // Strap code, address bits 3:2
    input  wire [1:0]       ADDR_SELECT_PIN_2, // Strap code, address bits 5:4
    input  wire [WIDTH-1:0] PORT_PIN_IN,  // Port pin levels
    output wire [WIDTH-1:0] PORT_PIN_OUT, // Port drive values
    output wire [WIDTH-1:0] PORT_PIN_OE,  // Port drive enables
    output wire             INT_N_OUT,   // Interrupt drive value, low
    output wire             INT_N_OE     // Interrupt pulled low when high
);

    // ==========================================================
    // Bus states, one-hot
    // ==========================================================
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RX   = 5'h02;
    localparam [4:0] ST_ACK  = 5'h04;
    localparam [4:0] ST_TX   = 5'h08;
    localparam [4:0] ST_MACK = 5'h10;

    wire [1:0]       bus_lvl;
    wire             scl;
    wire             sda;
    wire [WIDTH-1:0] pins;
    wire [5:0]       straps;

    reg              scl_d_ff;
    reg              sda_d_ff;
    reg  [4:0]       state_ff;
    reg  [3:0]       bit_ff;
    reg  [1:0]       byte_ff;
    reg  [7:0]       shift_ff;
    reg              read_ff;
    reg              sda_low_ff;
    reg  [1:0]       cmd_ff;
    reg  [WIDTH-1:0] dir_ff;
    reg  [WIDTH-1:0] out_ff;
    reg  [WIDTH-1:0] pol_ff;
    reg  [WIDTH-1:0] in_ff;
    reg  [1:0]       init_ff;
    reg  [6:0]       addr_ff;
    reg              int_ff;
    reg  [WIDTH-1:0] rd_data;

    // ==========================================================
    // Input conditioning
    // ==========================================================
    line_filter #(
        .WIDTH    (2),
        .FILT_CYC (`SPIKE_CYC),
        .CW       (4)
    ) u_bus_filter (
        .clk      (REF_CLK),
        .rst_n    (RSTN),
        .line_in  ({SCL_IN, SDA_IN}),
        .line_out (bus_lvl)
    );

    pin_sync #(
        .WIDTH   (WIDTH)
    ) u_port_sync (
        .clk     (REF_CLK),
        .rst_n   (RSTN),
        .pin_in  (PORT_PIN_IN),
        .pin_out (pins)
    );

    pin_sync #(
        .WIDTH   (6)
    ) u_strap_sync (
        .clk     (REF_CLK),
        .rst_n   (RSTN),
        .pin_in  ({ADDR_SELECT_PIN_2, ADDR_SELECT_PIN_1, ADDR_SELECT_PIN_0}),
        .pin_out (straps)
    );

    assign scl = bus_lvl[1];
    assign sda = bus_lvl[0];

    // Bus edges and framing conditions
    // Both lines pass the same filter, so their edge order survives;
    // edges closer than one REF_CLK cycle may still be misordered
    wire scl_rise  = scl & ~scl_d_ff;
    wire scl_fall  = ~scl & scl_d_ff;
    wire start_evt = scl & scl_d_ff & sda_d_ff & ~sda;
    wire stop_evt  = scl & scl_d_ff & ~sda_d_ff & sda;
    wire init_done = (init_ff == `INIT_CYC);

    // Read data mux, polarity applied to the live pin state
    always @* begin
        case (cmd_ff)
            `CMD_INPUT:     rd_data = pins ^ pol_ff;
            `CMD_OUTPUT:    rd_data = out_ff;
            `CMD_POLARITY:  rd_data = pol_ff;
            default:        rd_data = dir_ff;
        endcase
    end

    // ==========================================================
    // Strap capture and input register seeding after reset
    // ==========================================================
    // Sync stages reset to zero: take straps and the input register
    // only once both stages hold real pin levels, else a false
    // change would raise the interrupt at start-up
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            init_ff <= 2'h0;
            addr_ff <= 7'h00;
        end else if (!init_done) begin
            init_ff <= init_ff + 2'h1;
            addr_ff <= {ADDR_FIXED, straps};
        end
    end

    // ==========================================================
    // Bus target state machine and register file
    // ==========================================================
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            scl_d_ff   <= 1'b1;
            sda_d_ff   <= 1'b1;
            state_ff   <= ST_IDLE;
            bit_ff     <= 4'h0;
            byte_ff    <= `BYTE_ADDR;
            shift_ff   <= 8'h00;
            read_ff    <= 1'b0;
            sda_low_ff <= 1'b0;
            cmd_ff     <= `CMD_INPUT;
            dir_ff     <= `RST_DIRECTION;
            out_ff     <= `RST_OUTPUT;
            pol_ff     <= `RST_POLARITY;
            in_ff      <= {WIDTH{1'b0}};
        end else begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
            // Track pins until the first stable sample is in
            if (!init_done) begin
                in_ff <= pins;
            end
            if (stop_evt) begin
                state_ff   <= ST_IDLE;
                sda_low_ff <= 1'b0;
            end else if (start_evt) begin
                // Start or repeated start: expect an address byte
                state_ff   <= ST_RX;
                bit_ff     <= 4'h0;
                byte_ff    <= `BYTE_ADDR;
                sda_low_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        sda_low_ff <= 1'b0;
                    end
                    // Shift in eight bits, act on the falling edge after
                    ST_RX: begin
                        if (scl_rise && bit_ff != `BITS_PER_BYTE) begin
                            shift_ff <= {shift_ff[6:0], sda};
                            bit_ff   <= bit_ff + 4'h1;
                        end else if (scl_fall && bit_ff == `BITS_PER_BYTE) begin
                            bit_ff <= 4'h0;
                            if (byte_ff == `BYTE_ADDR) begin
                                if (shift_ff[7:1] == addr_ff) begin
                                    read_ff    <= shift_ff[0];
                                    sda_low_ff <= 1'b1;
                                    state_ff   <= ST_ACK;
                                end else begin
                                    state_ff <= ST_IDLE;
                                end
                            end else if (byte_ff == `BYTE_CMD) begin
                                cmd_ff     <= shift_ff[1:0];
                                sda_low_ff <= 1'b1;
                                state_ff   <= ST_ACK;
                            end else begin
                                // Data byte to the selected register
                                case (cmd_ff)
                                    `CMD_OUTPUT:    out_ff <= shift_ff;
                                    `CMD_POLARITY:  pol_ff <= shift_ff;
                                    `CMD_DIRECTION: dir_ff <= shift_ff;
                                    default:        ;
                                endcase
                                sda_low_ff <= 1'b1;
                                state_ff   <= ST_ACK;
                            end
                        end
                    end
                    // Hold acknowledge for one bus clock pulse
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (byte_ff == `BYTE_ADDR && read_ff) begin
                                // Load read data; input read re-arms interrupt
                                shift_ff   <= rd_data;
                                sda_low_ff <= ~rd_data[7];
                                bit_ff     <= 4'h0;
                                state_ff   <= ST_TX;
                                if (cmd_ff == `CMD_INPUT) begin
                                    in_ff <= pins;
                                end
                            end else begin
                                sda_low_ff <= 1'b0;
                                state_ff   <= ST_RX;
                                if (byte_ff != `BYTE_DATA) begin
                                    byte_ff <= byte_ff + 2'h1;
                                end
                            end
                        end
                    end
                    // Shift out eight bits on falling edges
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_ff == `LAST_TX_BIT) begin
                                sda_low_ff <= 1'b0;
                                state_ff   <= ST_MACK;
                            end else begin
                                shift_ff   <= {shift_ff[6:0], 1'b0};
                                sda_low_ff <= ~shift_ff[6];
                                bit_ff     <= bit_ff + 4'h1;
                            end
                        end
                    end
                    // Master acknowledge: more data, or stop sending
                    ST_MACK: begin
                        if (scl_rise) begin
                            read_ff <= ~sda;
                        end else if (scl_fall) begin
                            if (read_ff) begin
                                shift_ff   <= rd_data;
                                sda_low_ff <= ~rd_data[7];
                                bit_ff     <= 4'h0;
                                state_ff   <= ST_TX;
                                if (cmd_ff == `CMD_INPUT) begin
                                    in_ff <= pins;
                                end
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_ff   <= ST_IDLE;
                        sda_low_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Change detect on input pins
    // ==========================================================
    // Output pins masked by direction; a pin turned into an input
    // flags a change while its level differs from in_ff; an input register read or a return to that level clears it
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            int_ff <= 1'b0;
        end else begin
            int_ff <= init_done & (|((pins ^ in_ff) & dir_ff));
        end
    end

    // ==========================================================
    // Pin drivers
    // ==========================================================
    // Open-drain lines: drive value fixed low, only enables move,
    // so no line is ever driven high against its pull-up
    assign SDA_OUT      = 1'b0;
    assign SDA_OE       = sda_low_ff;
    assign PORT_PIN_OUT = out_ff;
    assign PORT_PIN_OE  = ~dir_ff;
    assign INT_N_OUT    = 1'b0;
    assign INT_N_OE     = int_ff;

endmodule // gpio_expander

// File: bench/gpio_expander_assertions.sv
// Purpose : Port checks for the serial port expander
// Assumes : Bus clock far slower than REF_CLK
// Notes   : Bound to the top module from the bench
`timescale 1ns/100ps

module gpio_expander_checker #(
    parameter WIDTH = 8                  // Port width
) (
    input wire             REF_CLK,      // Clock
    input wire             RSTN,         // Reset, active low
    input wire             SCL_IN,       // Bus clock level
    input wire             SDA_OUT,      // Data drive value
    input wire             SDA_OE,       // Data pull enable
    input wire [WIDTH-1:0] PORT_PIN_IN,  // Pin levels
    input wire [WIDTH-1:0] PORT_PIN_OUT, // Pin drive values
    input wire [WIDTH-1:0] PORT_PIN_OE,  // Pin drive enables
    input wire             INT_N_OUT,    // Interrupt drive value
    input wire             INT_N_OE      // Interrupt pull enable
);
    reg [3:0] quiet_ff;                  // Cycles since pins or drive enables last moved

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    // Count quiet cycles on pins and drive enables
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN)
            quiet_ff <= 4'h0;
        else if (!$stable(PORT_PIN_IN) || !$stable(PORT_PIN_OE))
            quiet_ff <= 4'h0;
        else if (quiet_ff != 4'hF)
            quiet_ff <= quiet_ff + 4'h1;
    end

    // =========================================================
    // Assertions
    // =========================================================
    rst_vals_a: assert property (
        $rose(RSTN) |-> PORT_PIN_OE == '0 && PORT_PIN_OUT == '1)
        else $error("port defaults wrong after reset");
    bus_idle_a: assert property (
        $rose(RSTN) |-> (!SDA_OE && !INT_N_OE) [*3])
        else $error("bus or interrupt active after reset");
    open_drain_a: assert property (!SDA_OUT && !INT_N_OUT)
        else $error("open-drain line driven high");
    dir_change_a: assert property (
        !$stable(PORT_PIN_OE) |-> !SCL_IN && !$past(SCL_IN, 8))
        else $error("direction moved outside a bus low phase");
    out_change_a: assert property (
        $changed(PORT_PIN_OUT) |-> !SCL_IN && !$past(SCL_IN, 8))
        else $error("output moved outside a bus low phase");
    sda_timing_a: assert property (
        $changed(SDA_OE) |-> !$past(SCL_IN, 6))
        else $error("data line moved while clock high");
    sda_hold_a: assert property (
        $changed(SDA_OE) |=> $stable(SDA_OE) [*8])
        else $error("data line pulse too short");
    int_cause_a: assert property (
        $rose(INT_N_OE) |-> quiet_ff < 4'hC)
        else $error("interrupt without pin change");

    cover property ($rose(INT_N_OE));
    cover property ($fell(INT_N_OE));
    cover property ($changed(PORT_PIN_OE));
endmodule // gpio_expander_checker

// File: bench/bus_master_model.sv
// Purpose : Behavioural two-wire bus master for the expander
// Assumes : Data line resolved with pull-up in the bench
// Notes   : Clock stands high between frames
`timescale 1ns/100ps

module bus_master_model #(
    parameter Q = 250                // Quarter bus period, 1 MHz
) (
    input  wire REF_CLK,             // Bench clock, for alignment
    input  wire sda,                 // Resolved data line
    output reg  scl,                 // Bus clock
    output reg  sda_pull             // High pulls data low
);
    reg glitch_en;                   // Spike data high in high phase

    // Idle bus
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        glitch_en = 1'b0;
    end

    // =========================================================
    // Bus tasks
    // =========================================================
    task bit_io(input b, output r);
        begin
            sda_pull = !b;
            #Q scl = 1'b1;
            r = sda;
            #Q sda_pull = !b && !glitch_en;
            #20 sda_pull = !b;
            #(Q - 20) scl = 1'b0;
            #Q;
        end
    endtask

    // Start or repeated start
    task start;
        begin
            @(posedge REF_CLK);
            #1 sda_pull = 1'b0;
            #Q scl = 1'b1;
            #Q sda_pull = 1'b1;
            #Q scl = 1'b0;
            #Q;
        end
    endtask

    task stop;
        begin
            sda_pull = 1'b1;
            #Q scl = 1'b1;
            #Q sda_pull = 1'b0;
            #(2 * Q);
        end
    endtask

    // Byte out, MSB first, then sample acknowledge
    task byte_tx(input [7:0] d, output ack);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bit_io(d[i], r);
            bit_io(1'b1, ack);
        end
    endtask

    task byte_rx(input last, output [7:0] d);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bit_io(1'b1, d[i]);
            bit_io(last, r);
        end
    endtask
endmodule // bus_master_model

// File: bench/gpio_expander_test.sv
// Purpose : Self-checking bench for the serial port expander
// Assumes : Bus master model at 1 MHz, pins modelled in the bench
// Notes   : Random straps, pins and register values from a fixed seed
`timescale 1ns/100ps

module gpio_expander_test;
    reg        ref_clk;      // 200 MHz clock
    reg        rstn;         // Reset, active low
    reg  [1:0] strap0;       // Address strap codes
    reg  [1:0] strap1;
    reg  [1:0] strap2;
    reg  [7:0] ext_pins;     // Levels of external pin drivers
    wire       scl;          // Bus clock
    wire       m_pull;       // Master pulls data low
    wire       sda_line;     // Resolved data line
    wire       sda_out;
    wire       sda_oe;
    wire       int_out;
    wire       int_oe;
    wire [7:0] pin_out;
    wire [7:0] pin_oe;
    wire [7:0] pin_lvl;      // Resolved port pins
    integer    num_errors;
    integer    n_checks;
    integer    seed;
    integer    k;
    reg  [6:0] addr;
    reg  [7:0] rd;
    reg  [7:0] o;
    reg  [7:0] d;
    reg  [7:0] p;
    reg        ack;

    // Open-drain data line with pull-up; pins follow their drivers
    assign sda_line = (m_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    assign pin_lvl  = (pin_oe & pin_out) | (~pin_oe & ext_pins);

    gpio_expander u_dut (
        .REF_CLK(ref_clk), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SELECT_PIN_0(strap0),
        .ADDR_SELECT_PIN_1(strap1), .ADDR_SELECT_PIN_2(strap2),
        .PORT_PIN_IN(pin_lvl), .PORT_PIN_OUT(pin_out), .PORT_PIN_OE(pin_oe),
        .INT_N_OUT(int_out), .INT_N_OE(int_oe));

    bus_master_model u_master (
        .REF_CLK(ref_clk), .sda(sda_line), .scl(scl), .sda_pull(m_pull));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // =========================================================
    // Tasks
    // =========================================================
    task check(input [7:0] seen, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task summarize;
        begin
            if (num_errors == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Address with write, then command with random ignored upper bits
    task addr_cmd(input [1:0] cmd);
        reg [5:0] junk;
        begin
            junk = $random(seed);
            u_master.start;
            u_master.byte_tx({addr, 1'b0}, ack);
            check({7'h00, ack}, 8'h00);
            u_master.byte_tx({junk, cmd}, ack);
            check({7'h00, ack}, 8'h00);
        end
    endtask

    task wr_reg(input [1:0] cmd, input [7:0] val);
        begin
            addr_cmd(cmd);
            u_master.byte_tx(val, ack);
            check({7'h00, ack}, 8'h00);
            u_master.stop;
        end
    endtask

    task rd_reg(input [1:0] cmd, output [7:0] val);
        begin
            addr_cmd(cmd);
            u_master.start;
            u_master.byte_tx({addr, 1'b1}, ack);
            check({7'h00, ack}, 8'h00);
            u_master.byte_rx(1'b1, val);
            u_master.stop;
        end
    endtask

    // Flip external pins, then look at the interrupt
    task flip(input [7:0] m, input e);
        begin
            @(posedge ref_clk);
            #1 ext_pins = ext_pins ^ m;
            repeat (10) @(posedge ref_clk);
            check({7'h00, int_oe}, {7'h00, e});
        end
    endtask

    // Expected input read: pin levels, inverted where polarity set
    function [7:0] exp_in(input [7:0] dir, input [7:0] outv, input [7:0] pol);
        exp_in = ((~dir & outv) | (dir & ext_pins)) ^ pol;
    endfunction

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        seed = 32'h190F7AB2;
        num_errors = 0;
        n_checks = 0;
        rstn = 1'b0;
        {strap2, strap1, strap0} = $random(seed);
        ext_pins = $random(seed);
        repeat (12) @(posedge ref_clk);
        #1 rstn = 1'b1;
        addr = {1'b1, strap2, strap1, strap0};
        repeat (10) @(posedge ref_clk);
        check(pin_oe, 8'h00);
        check(pin_out, 8'hFF);
        for (k = 1; k < 4; k = k + 1) begin
            rd_reg(k[1:0], rd);
            check(rd, (k == 2) ? 8'h00 : 8'hFF);
        end
        // Foreign address is not acknowledged
        u_master.start;
        u_master.byte_tx({addr ^ (7'h01 << ({$random(seed)} % 7)), 1'b0}, ack);
        check({7'h00, ack}, 8'h01);
        u_master.stop;
        // Writes, some with spikes on the data line
        o = $random(seed);
        d = ($random(seed) | 8'h80) & 8'hFE;
        p = $random(seed);
        u_master.glitch_en = 1'b1;
        wr_reg(2'h1, o);
        wr_reg(2'h3, d);
        u_master.glitch_en = 1'b0;
        wr_reg(2'h2, p);
        wr_reg(2'h0, ~p);  // Input register: acked, ignored
        check(pin_out, o);
        check(pin_oe, ~d);
        rd_reg(2'h1, rd);
        check(rd, o);
        rd_reg(2'h3, rd);
        check(rd, d);
        rd_reg(2'h2, rd);
        check(rd, p);
        // Input reads and the interrupt
        rd_reg(2'h0, rd);
        check(rd, exp_in(d, o, p));
        flip(8'h80, 1'b1);
        flip(8'h80, 1'b0);
        flip(8'h80, 1'b1);
        // Two-byte read with no command byte: last register again
        u_master.start;
        u_master.byte_tx({addr, 1'b1}, ack);
        check({7'h00, ack}, 8'h00);
        u_master.byte_rx(1'b0, rd);
        check(rd, exp_in(d, o, p));
        u_master.byte_rx(1'b1, rd);
        check(rd, exp_in(d, o, p));
        u_master.stop;
        flip(8'h00, 1'b0);
        summarize;
    end

    // Watchdog, above the ~430 us of bus traffic
    initial begin
        #480000;
        num_errors = num_errors + 1;
        summarize;
    end
endmodule // gpio_expander_test

bind gpio_expander gpio_expander_checker #(.WIDTH(WIDTH)) u_chk (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .PORT_PIN_IN(PORT_PIN_IN), .PORT_PIN_OUT(PORT_PIN_OUT),
    .PORT_PIN_OE(PORT_PIN_OE), .INT_N_OUT(INT_N_OUT), .INT_N_OE(INT_N_OE));
